/* tb_top.sv */
/*
 * Self-checking bench for the virtual terminal mapper.
 * Assumes the far-side model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
   import vio_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, init_done;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [4:0]  physical_input_terminal, virtual_input, virtual_output;
   logic [4:0]  pin_cmd = '0, m, f, p;
   logic [47:0] analogue_channel_mv, mv_cmd = '0;
   logic [63:0] drive_status, function_request, stat_cmd = '0;
   logic [2:0]  analogue_din, st;
   logic [15:0] v;
   int          err_count = 0, num_checks = 0, k, n, fn;
   localparam logic [15:0] MVT [5] = '{16'h07D0, 16'h0BB8, 16'h1388,
                                       16'h1B58, 16'h2328};
   localparam logic [7:0] OFS [7] = '{OFS_SRC_MODE, OFS_FORCED,
      OFS_AIN_POL, OFS_VOUT_POL, OFS_AIN_FUNC0, OFS_VOUT_FUNC0, OFS_VOUT_DLY0};
   always #25 aclk = ~aclk;
   vio_far_end far (.aclk, .pin_cmd, .mv_cmd, .stat_cmd,
      .pins(physical_input_terminal), .mv(analogue_channel_mv),
      .stat(drive_status));
   vio_mapper #(.TICK_CYCLES(4)) DUT (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .physical_input_terminal, .analogue_channel_mv, .drive_status,
      .virtual_input, .virtual_output, .analogue_din, .function_request,
      .init_done);
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   // Handshakes are judged at the rising edge; one idle edge ends each task.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic       bh;
      logic [1:0] br;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         bh = s_axi_bvalid;
         br = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
      check(br, er);
      @(posedge aclk);
   endtask : wr
   task automatic rd_reg(input logic [7:0] a);
      logic rh;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         rh = s_axi_rvalid;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd_reg
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      test_done();
   end
   initial begin
      void'($urandom(45677));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < 7; k++) begin
         rd_reg(OFS[k]);
         check({rr, rd}, {RESP_OKAY, 32'h0});
      end
      rd_reg(8'h7C);
      check(rr, RESP_SLVERR);
      n = 0;
      while (init_done !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      rd_reg(OFS_STATUS);
      check(rd, 32'h0001_0000);
      check(function_request, 64'h0);
      for (k = 0; k < 8; k++) begin
         m = (k == 0) ? 5'h01 : 5'($urandom);
         f = (k == 0) ? 5'h01 : 5'($urandom);
         p = (k == 0) ? 5'h00 : 5'($urandom);
         pin_cmd <= 5'($urandom);
         wr(OFS_SRC_MODE, {27'h0, m}, RESP_OKAY);
         wr(OFS_FORCED, {27'h0, f}, RESP_OKAY);
         wr(OFS_VOUT_POL, {27'h0, p}, RESP_OKAY);
         repeat (12) @(posedge aclk);
         check(virtual_output, pin_cmd ^ p);
         check(virtual_input, (m & f) | (~m & (pin_cmd ^ p)));
      end
      wr(OFS_VOUT_POL, 32'h0, RESP_OKAY);
      fn = 1 + $urandom % 40;
      stat_cmd <= {$urandom, $urandom};
      wr(OFS_VOUT_FUNC0, fn, RESP_OKAY);
      repeat (10) @(posedge aclk);
      check(virtual_output, {pin_cmd[4:1], stat_cmd[fn]});
      wr(OFS_VOUT_FUNC0, 32'h29, RESP_SLVERR);
      wr(OFS_AIN_FUNC0, 32'h3C, RESP_SLVERR);
      wr(OFS_VOUT_DLY0, 32'h8CA1, RESP_SLVERR);
      rd_reg(OFS_VOUT_FUNC0);
      check(rd, fn);
      wr(OFS_VOUT_FUNC0, 32'h0, RESP_OKAY);
      wr(OFS_VOUT_DLY0, 32'h3, RESP_OKAY);
      repeat (10) @(posedge aclk);
      pin_cmd <= pin_cmd ^ 5'h01;
      repeat (8) @(posedge aclk);
      check(virtual_output[0], !pin_cmd[0]);
      n = 0;
      while (virtual_output[0] !== pin_cmd[0] && n < 40) begin
         @(posedge aclk);
         n++;
      end
      check(n >= 3 && n < 40, 1'b1);
      wr(OFS_AIN_FUNC0, 32'h5, RESP_OKAY);
      st = '0;
      for (k = 0; k < 60; k++) begin
         if (k % 30 == 0) begin
            p = 5'($urandom);
            wr(OFS_AIN_POL, {29'h0, p[2:0]}, RESP_OKAY);
            repeat (8) @(posedge aclk);
         end
         for (n = 0; n < 3; n++) begin
            v = MVT[$urandom % 5];
            mv_cmd[n*16 +: 16] <= v;
            if (v >= 16'h1B58) st[n] = 1'b1;
            else if (v <= 16'h0BB8) st[n] = 1'b0;
         end
         repeat (4) @(posedge aclk);
         check(analogue_din, st ^ p[2:0]);
         @(posedge aclk);
         check(function_request, (st[0] ^ p[0]) ? 64'h20 : 64'h0);
      end
      test_done();
   end
endmodule : tb_top

/* vio_far_end.sv */
/*
 * Far side: input terminals, analogue converter and drive status.
 * Assumes the bench steers it just after rising clock edges.
 */
`timescale 1ns/1ps
module vio_far_end (
   input  wire logic        aclk,
   input  wire logic [4:0]  pin_cmd,
   input  wire logic [47:0] mv_cmd,
   input  wire logic [63:0] stat_cmd,
   output logic      [4:0]  pins,
   output logic      [47:0] mv,
   output logic      [63:0] stat
);
   initial begin
      pins = '0;
      mv = '0;
      stat = '0;
   end
   // Terminals are asynchronous, so they move well off the clock edge.
   always @(pin_cmd) pins <= #13 pin_cmd;
   always @(posedge aclk) begin
      mv <= mv_cmd;
      stat <= stat_cmd;
   end
endmodule : vio_far_end

/* vio_mapper.sv */
/*
 * Virtual input and output routing for the drive terminal logic.
 * Assumes physical terminals are asynchronous, analogue levels come in
 * millivolts from a converter on this clock, and drive status bits are
 * indexed by function code on the same clock.
 */
`timescale 1ns/1ps
module vio_mapper #(
   parameter int TICK_CYCLES = vio_pkg::TICK_CYCLES
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [vio_pkg::NVIN-1:0] physical_input_terminal,
   input  wire logic [vio_pkg::NAIN*vio_pkg::MV_W-1:0] analogue_channel_mv,
   input  wire logic [63:0]            drive_status,
   output logic [vio_pkg::NVIN-1:0]    virtual_input,
   output logic [vio_pkg::NVIN-1:0]    virtual_output,
   output logic [vio_pkg::NAIN-1:0]    analogue_din,
   output logic [63:0]                 function_request,
   output logic                        init_done
);
   import vio_pkg::*;

   if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << 24)) begin : g_bad_tick
      $error("TICK_CYCLES must lie between 1 and 2**24");
   end

   logic [NVIN-1:0]   src_mode_r, forced_r, vout_pol_r;
   logic [NAIN-1:0]   ain_pol_r, ain_lvl_r;
   logic [FUNC_W-1:0] ain_func_r [NAIN];
   logic [FUNC_W-1:0] vout_func_r [NVIN];
   logic [DLY_W-1:0]  vout_dly_r [NVIN];
   logic [DLY_W-1:0]  dly_cnt_r [NVIN];
   logic [NVIN-1:0]   raw_last_r, vout_r;
   logic [NVIN-1:0]   pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
   logic [NVIN-1:0]   vin_r;
   logic [NAIN-1:0]   adin_r;
   logic [63:0]       req_r;
   logic [23:0]       tick_cnt_r;
   logic [4:0]        init_cnt_r;
   logic              init_r;

   // Bus slave: write taken once address and data have both arrived.
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  bresp_r, rresp_r;
   wire         wr_go = aw_have_r && w_have_r && !bvalid_r;
   wire         rd_go = s_axi_arvalid && !rvalid_r;
   wire  [7:0]  wa    = awaddr_r;
   wire  [7:0]  ra    = s_axi_araddr;
   wire         w_b0  = wstrb_r[0];
   wire         w_b1  = wstrb_r[1];

   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready  = !w_have_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   wire wr_ctl = (wa == OFS_SRC_MODE) || (wa == OFS_FORCED)
              || (wa == OFS_AIN_POL) || (wa == OFS_VOUT_POL);
   wire wr_af  = (wa >= OFS_AIN_FUNC0) && (wa < OFS_AIN_FUNC0 + 8'(4*NAIN))
              && (wa[1:0] == 2'h0);
   wire wr_vf  = (wa >= OFS_VOUT_FUNC0) && (wa < OFS_VOUT_FUNC0 + 8'(4*NVIN))
              && (wa[1:0] == 2'h0);
   wire wr_vd  = (wa >= OFS_VOUT_DLY0) && (wa < OFS_VOUT_DLY0 + 8'(4*NVIN))
              && (wa[1:0] == 2'h0);
   wire [2:0] wr_idx = wa[4:2];
   // The analogue codes start at 0x10, so their index is address bits 3:2.
   wire [2:0] af_idx = {1'b0, wa[3:2]};
   wire wr_ok  = wr_ctl || wr_af || wr_vf || wr_vd;
   // Out-of-range settings are refused with SLVERR and leave the register.
   wire wr_bad = (wr_af && wdata_r[FUNC_W-1:0] > AIN_FUNC_MAX)
              || (wr_vf && wdata_r[FUNC_W-1:0] > VOUT_FUNC_MAX)
              || (wr_vf || wr_af) && wdata_r[7:FUNC_W] != 2'h0
              || (wr_vd && wdata_r[DLY_W-1:0] > DLY_MAX);
   wire wr_en  = wr_go && wr_ok && !wr_bad;

   wire [2:0] rd_idx = ra[4:2];
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_val = 32'h0;
      rd_ok  = 1'b1;
      if (ra[1:0] != 2'h0)
         rd_ok = 1'b0;
      else if (ra == OFS_SRC_MODE)
         rd_val[NVIN-1:0] = src_mode_r;
      else if (ra == OFS_FORCED)
         rd_val[NVIN-1:0] = forced_r;
      else if (ra == OFS_AIN_POL)
         rd_val[NAIN-1:0] = ain_pol_r;
      else if (ra == OFS_VOUT_POL)
         rd_val[NVIN-1:0] = vout_pol_r;
      else if (ra >= OFS_AIN_FUNC0 && ra < OFS_AIN_FUNC0 + 8'(4*NAIN))
         rd_val[FUNC_W-1:0] = ain_func_r[ra[3:2]];
      else if (ra >= OFS_VOUT_FUNC0 && ra < OFS_VOUT_FUNC0 + 8'(4*NVIN))
         rd_val[FUNC_W-1:0] = vout_func_r[rd_idx];
      else if (ra >= OFS_VOUT_DLY0 && ra < OFS_VOUT_DLY0 + 8'(4*NVIN))
         rd_val[DLY_W-1:0] = vout_dly_r[rd_idx];
      else if (ra == OFS_STATUS)
         rd_val[16:0] = {init_r, adin_r, vout_r, 3'h0, vin_r};
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         rvalid_r  <= 1'b0;
         awaddr_r  <= 8'h0;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
         rdata_r   <= 32'h0;
         bresp_r   <= RESP_OKAY;
         rresp_r   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (wr_ok && !wr_bad) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   // Setting registers; only byte lane 0 (and lane 1 for delays) is used.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_mode_r <= '0;
         forced_r   <= '0;
         ain_pol_r  <= '0;
         vout_pol_r <= '0;
      end else if (wr_en && w_b0) begin
         if (wa == OFS_SRC_MODE)
            src_mode_r <= wdata_r[NVIN-1:0];
         if (wa == OFS_FORCED)
            forced_r <= wdata_r[NVIN-1:0];
         if (wa == OFS_AIN_POL)
            ain_pol_r <= wdata_r[NAIN-1:0];
         if (wa == OFS_VOUT_POL)
            vout_pol_r <= wdata_r[NVIN-1:0];
      end
   end

   // Three-stage sampling of the asynchronous terminals.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         pin_r    <= '0;
      end else begin
         pin_s1_r <= physical_input_terminal;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         for (int i = 0; i < NVIN; i++)
            if (pin_s2_r[i] == pin_s3_r[i])
               pin_r[i] <= pin_s3_r[i];
      end
   end

   // Shared 0.1 s tick and the power-on initialisation window.
   wire tick = (tick_cnt_r == 24'(TICK_CYCLES - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= 24'h0;
         init_cnt_r <= 5'h0;
         init_r     <= 1'b0;
      end else begin
         tick_cnt_r <= tick ? 24'h0 : tick_cnt_r + 24'h1;
         if (init_cnt_r == 5'(INIT_CYCLES - 1))
            init_r <= 1'b1;
         else
            init_cnt_r <= init_cnt_r + 5'h1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NVIN; g++) begin : g_vout
         wire [FUNC_W-1:0] fsel = vout_func_r[g];
         wire raw = (fsel == 6'h0) ? pin_r[g]
                  : drive_status[fsel];
         wire dly_done = (dly_cnt_r[g] >= vout_dly_r[g]);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               vout_func_r[g] <= 6'h0;
               vout_dly_r[g]  <= 16'h0;
               dly_cnt_r[g]   <= 16'h0;
               raw_last_r[g]  <= 1'b0;
               vout_r[g]      <= 1'b0;
               vin_r[g]       <= 1'b0;
            end else begin
               if (wr_en && wr_vf && wr_idx == 3'(g) && w_b0)
                  vout_func_r[g] <= wdata_r[FUNC_W-1:0];
               if (wr_en && wr_vd && wr_idx == 3'(g) && w_b0 && w_b1)
                  vout_dly_r[g] <= wdata_r[DLY_W-1:0];
               raw_last_r[g] <= raw;
               if (raw != raw_last_r[g])
                  dly_cnt_r[g] <= 16'h0;
               else if (tick && !dly_done)
                  dly_cnt_r[g] <= dly_cnt_r[g] + 16'h1;
               if (raw == raw_last_r[g] && dly_done)
                  vout_r[g] <= raw_last_r[g] ^ vout_pol_r[g];
               vin_r[g] <= src_mode_r[g] ? forced_r[g]
                         : vout_r[g];
            end
         end
      end
      for (g = 0; g < NAIN; g++) begin : g_ain
         wire [MV_W-1:0] mv = analogue_channel_mv[g*MV_W +: MV_W];
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ain_func_r[g] <= 6'h0;
               ain_lvl_r[g]  <= 1'b0;
               adin_r[g]     <= 1'b0;
            end else begin
               if (wr_en && wr_af && af_idx == 3'(g) && w_b0)
                  ain_func_r[g] <= wdata_r[FUNC_W-1:0];
               if (mv >= AIN_HIGH_MV)
                  ain_lvl_r[g] <= 1'b1;
               else if (mv <= AIN_LOW_MV)
                  ain_lvl_r[g] <= 1'b0;
               adin_r[g] <= ain_lvl_r[g] ^ ain_pol_r[g];
            end
         end
      end
   endgenerate

   // Function requests come from the analogue channels only: virtual inputs
   // have no function code register here, so they raise no request.
   logic [63:0] req_nxt;
   always_comb begin
      req_nxt = 64'h0;
      for (int i = 0; i < NAIN; i++)
         if (adin_r[i])
            req_nxt[ain_func_r[i]] = 1'b1;
      req_nxt[0] = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         req_r <= 64'h0;
      else
         req_r <= init_r ? req_nxt : 64'h0;
   end

   assign virtual_input    = vin_r;
   assign virtual_output   = vout_r;
   assign analogue_din     = adin_r;
   assign function_request = req_r;
   assign init_done        = init_r;
endmodule : vio_mapper

/* vio_mapper_sva.sv */
/*
 * Port checks for the virtual terminal mapper.
 * Assumes every register write uses all four byte lanes.
 */
`timescale 1ns/1ps
module vio_mapper_sva
   import vio_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [47:0] analogue_channel_mv,
   input wire logic [4:0]  virtual_input,
   input wire logic [4:0]  virtual_output,
   input wire logic [2:0]  analogue_din,
   input wire logic [63:0] function_request,
   input wire logic        init_done
);
   logic [7:0]  wa_r;
   logic [31:0] wd_r;
   logic [4:0]  src_r, frc_r;
   logic [2:0]  apol_r, quiet_r;
   logic        q, hi0, lo0, mid0;
   // Shadow settings; checks wait until no write has been near for a while.
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
      if (!aresetn) begin
         src_r <= '0;
         frc_r <= '0;
         apol_r <= '0;
         quiet_r <= '0;
      end else begin
         if (s_axi_bvalid && s_axi_bresp == RESP_OKAY) begin
            if (wa_r == OFS_SRC_MODE) src_r <= wd_r[4:0];
            if (wa_r == OFS_FORCED) frc_r <= wd_r[4:0];
            if (wa_r == OFS_AIN_POL) apol_r <= wd_r[2:0];
         end
         if (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid) quiet_r <= '0;
         else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
      end
   end
   assign q    = quiet_r == 3'h7;
   assign hi0  = q && analogue_channel_mv[15:0] >= AIN_HIGH_MV;
   assign lo0  = q && analogue_channel_mv[15:0] <= AIN_LOW_MV;
   assign mid0 = q && !hi0 && !lo0;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_vin_forced: assert property (q |->
      ((virtual_input ^ frc_r) & src_r) == '0) else $error("forced bad");
   a_vin_follow: assert property (q |-> ((virtual_input
      ^ $past(virtual_output)) & ~src_r) == '0) else $error("follow bad");
   a_init_gate: assert property (!init_done |->
      function_request == '0) else $error("request before init");
   a_init_time: assert property ($rose(aresetn) |->
      (!init_done)[*8] ##[6:10] init_done) else $error("init late");
   a_init_stays: assert property (init_done |=> init_done)
      else $error("init dropped");
   a_req_bound: assert property (!function_request[0] &&
      $countones(function_request) <= 3) else $error("bad request");
   a_ain_hold: assert property (mid0[*3] |->
      $stable(analogue_din[0])) else $error("hysteresis lost");
   a_ain_level: assert property (hi0[*3] |->
      analogue_din[0] == !apol_r[0]) else $error("level wrong");
   a_ain_flip: assert property (hi0[*3] ##1 lo0[*3] |->
      analogue_din[0] != $past(analogue_din[0], 3)) else $error("no flip");
endmodule : vio_mapper_sva

bind vio_mapper vio_mapper_sva u_sva (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .analogue_channel_mv, .virtual_input,
   .virtual_output, .analogue_din, .function_request, .init_done
);

/* vio_pkg.sv */
/*
 * Constants and register map of the virtual terminal mapper.
 * Assumes a 20 MHz control clock and an AXI4-Lite register bus.
 */
// Notes on behaviour
// - A source-mode bit per virtual input picks the paired virtual output (0) or the forced-state bit (1).
// - Virtual input x follows only virtual output x, for x from 1 to 5.
// - In forced mode each virtual input takes its own bit of the forced-state setting.
// - A forced bit of 1 makes the virtual input active and 0 leaves it inactive.
// - Once initialisation is done, active virtual inputs drive their assigned function codes; here only the analogue channels raise requests.
// - Each of the three analogue channels has a function code from 0 to 59, default 0.
// - An analogue channel reads high at 7 V or more, low at 3 V or less, and holds in between.
// - An analogue polarity bit of 0 means active high and 1 active low, all defaulting to 0.
// - A virtual output with function 0 mirrors the same-numbered physical input terminal.
// - A virtual output function from 1 to 40 carries that drive status function.
// - Channel bits map in order: bit 0 to channel 1 up to bit 4 to channel 5.
package vio_pkg;
   localparam int          NVIN           = 5;
   localparam int          NAIN           = 3;
   localparam int          FUNC_W         = 6;
   localparam int          DLY_W          = 16;
   localparam int          MV_W           = 16;
   localparam logic [5:0]  AIN_FUNC_MAX   = 6'h3B;
   localparam logic [5:0]  VOUT_FUNC_MAX  = 6'h28;
   localparam logic [15:0] DLY_MAX        = 16'h8CA0;
   localparam logic [15:0] AIN_HIGH_MV    = 16'h1B58;
   localparam logic [15:0] AIN_LOW_MV     = 16'h0BB8;
   localparam int          CLK_HZ         = 20000000;
   localparam int          TICK_MS        = 100;
   localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
   localparam int          INIT_CYCLES    = 16;
   localparam logic [7:0]  OFS_SRC_MODE   = 8'h00;
   localparam logic [7:0]  OFS_FORCED     = 8'h04;
   localparam logic [7:0]  OFS_AIN_POL    = 8'h08;
   localparam logic [7:0]  OFS_VOUT_POL   = 8'h0C;
   localparam logic [7:0]  OFS_AIN_FUNC0  = 8'h10;
   localparam logic [7:0]  OFS_VOUT_FUNC0 = 8'h20;
   localparam logic [7:0]  OFS_VOUT_DLY0  = 8'h40;
   localparam logic [7:0]  OFS_STATUS     = 8'h60;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : vio_pkg
